// ==== hdl/ssbs_defs.vh ====
// Constants for the synchronous SRAM burst and sleep controller
// Overview of operation
// - Hold cycle (clock enable off) changes no burst or data state; sleep and recovery still advance
// - Advance high in an active burst steps the burst counter and accesses the counter address
// - Advance low loads the presented address as the burst start
// - Counter wraps after four addresses; fifth clock repeats the loaded address
// - Burst order pin low picks linear, high picks interleaved
// - Linear order adds the step modulo four to the loaded low bits
// - Interleaved order XORs the loaded low bits with the step
// - Sleep input low means active, high means standby
// - Unconnected sleep pin reads low, unconnected flow-through pin reads high
// - Sleep mode and deselect start two cycles after sleep goes high
// - All internal state is kept through sleep
// - In sleep command, mode and register-write inputs are ignored, register reads still work; data outputs float
// - Sleep input is asynchronous, active high, independent of clock enable
// - Reads resume once sleep drops; writes resume once the recovery interval has run out
// - Flow-through or pipeline mode follows a static select input
// - Back-to-back reads, writes and read-write changes need no gap
// - Two-bit counter steps on every continue cycle of an active burst, read or write
// - Clock enable low suspends all burst and register operations for that cycle, not sleep or recovery
`ifndef SSBS_DEFS_VH
`define SSBS_DEFS_VH

`define SSBS_ADDR_W        18
`define SSBS_BYTES         4
`define SSBS_CNT_W         2

`define SSBS_RADDR_W       4
`define SSBS_REG_STATUS    4'h0
`define SSBS_REG_RECOVERY  4'h4
`define SSBS_REG_ADDR      4'h8

`define SSBS_ST_SLEEP      0
`define SSBS_ST_RECOV      1
`define SSBS_ST_BURST      2
`define SSBS_ST_WRITE      3
`define SSBS_ST_FLOW       4
`define SSBS_ST_ORDER      5
`define SSBS_ST_IDX_LO     6

`define SSBS_CLK_MHZ       250
`define SSBS_T_RECOV_NS    100
`define SSBS_RECOV_CYC     ((`SSBS_T_RECOV_NS * `SSBS_CLK_MHZ + 999) / 1000)
`define SSBS_RECOV_W       8

`endif

// ==== hdl/ssbs_ctrl.v ====
// Burst address generator and sleep control of a synchronous SRAM
`include "ssbs_defs.vh"

// Limitations worth knowing before use:
// - Mode pins pass a slow two-flop path; change them only while idle.
// - Sleep and the recovery count ignore clock enable, since sleep is
//   asynchronous and recovery is measured in real time.
// - Writes issued during sleep or recovery become write aborts.
// - Only the burst address and access strobes are generated here; data paths sit outside.
// - A continue after a deselect stays deselected until the next load.

module ssbs_ctrl (
  input  wire                            clock,
  input  wire                            nrst,
  input  wire                            clk_en,
  input  wire [`SSBS_RADDR_W-1:0]        reg_addr,
  input  wire [31:0]                     reg_wdata,
  input  wire                            reg_wr,
  input  wire                            reg_rd,
  output wire [31:0]                     reg_rdata,
  input  wire                            chip_select,
  input  wire                            advance_load_n,
  input  wire                            write_n,
  input  wire [`SSBS_BYTES-1:0]          byte_wr_n,
  input  wire [`SSBS_ADDR_W-1:0]         addr,
  input  wire                            burst_order_select,
  input  wire                            flow_through_select,
  input  wire                            sleep_request,
  output wire [`SSBS_ADDR_W-1:0]         mem_addr,
  output wire                            mem_rd,
  output wire                            mem_wr,
  output wire [`SSBS_BYTES-1:0]          mem_byte_en,
  output wire                            dq_drive_n,
  output wire                            wdata_take,
  output wire                            deselected,
  output wire                            sleep_active,
  output wire                            recovering,
  output wire [`SSBS_CNT_W-1:0]          burst_index
);

  // ==========================================================
  // Power states
  localparam [2:0] ST_RUN   = 3'b001;
  localparam [2:0] ST_SLEEP = 3'b010;
  localparam [2:0] ST_RECOV = 3'b100;

  localparam integer             RECOV_CYC = `SSBS_RECOV_CYC;
  localparam [`SSBS_RECOV_W-1:0] RECOV_RST = RECOV_CYC[`SSBS_RECOV_W-1:0];

  // ==========================================================
  // Burst address step
  function [`SSBS_CNT_W-1:0] burst_low;
    input [`SSBS_CNT_W-1:0] start;
    input [`SSBS_CNT_W-1:0] step;
    input                   order;
    begin
      if (order) begin
        burst_low = start ^ step;
      end else begin
        burst_low = start + step;
      end
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  reg                            zz_s1_q;
  reg                            sleep_q;
  reg                            order_s1_q;
  reg                            order_q;
  reg                            ft_s1_q;
  reg                            ft_q;

  // Sleep is sampled on every edge, clock enable or not
  always @(posedge clock) begin
    if (!nrst) begin
      zz_s1_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      zz_s1_q <= sleep_request;
      sleep_q <= zz_s1_q;
    end
  end

  // Mode pins are static, so a slow two-flop path costs nothing
  always @(posedge clock) begin
    if (!nrst) begin
      order_s1_q <= 1'b0;
      order_q    <= 1'b0;
      ft_s1_q    <= 1'b1;
      ft_q       <= 1'b1;
    end else if (clk_en && !sleep_q) begin
      order_s1_q <= burst_order_select;
      order_q    <= order_s1_q;
      ft_s1_q    <= flow_through_select;
      ft_q       <= ft_s1_q;
    end
  end

  // ==========================================================
  // Power state machine
  reg  [2:0]                     st_q;
  reg  [2:0]                     st_d;
  reg  [`SSBS_RECOV_W-1:0]       rcnt_q;
  reg  [`SSBS_RECOV_W-1:0]       rcnt_d;
  reg  [`SSBS_RECOV_W-1:0]       recov_cfg_q;
  reg                            sleep_act_q;
  reg                            recov_act_q;
  wire                           st_is_run;
  wire                           nx_is_sleep;
  wire                           nx_is_recov;

  // One-hot bits read directly, so no compare chain on the state
  assign st_is_run   = st_q[0];
  assign nx_is_sleep = st_d[1];
  assign nx_is_recov = st_d[2];

  always @* begin
    st_d   = st_q;
    rcnt_d = rcnt_q;
    case (st_q)
      ST_RUN: begin
        if (sleep_q) begin
          st_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!sleep_q) begin
          st_d   = ST_RECOV;
          rcnt_d = recov_cfg_q;
        end
      end
      ST_RECOV: begin
        if (sleep_q) begin
          st_d = ST_SLEEP;
        end else if (rcnt_q == {`SSBS_RECOV_W{1'b0}}) begin
          st_d = ST_RUN;
        end else begin
          rcnt_d = rcnt_q - 1'b1;
        end
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
  end

  // Recovery is real time, so it counts even while clock enable is low
  always @(posedge clock) begin
    if (!nrst) begin
      st_q        <= ST_RUN;
      rcnt_q      <= {`SSBS_RECOV_W{1'b0}};
      sleep_act_q <= 1'b0;
      recov_act_q <= 1'b0;
    end else begin
      st_q        <= st_d;
      rcnt_q      <= rcnt_d;
      sleep_act_q <= nx_is_sleep;
      recov_act_q <= nx_is_recov;
    end
  end

  // ==========================================================
  // Byte lanes
  wire [`SSBS_BYTES-1:0]         lane_req;
  genvar                         gi;

  // Byte write pins are active low; one lane per byte
  generate
    for (gi = 0; gi < `SSBS_BYTES; gi = gi + 1) begin : g_lane
      assign lane_req[gi] = ~byte_wr_n[gi];
    end
  endgenerate

  // ==========================================================
  // Burst command decode
  reg  [`SSBS_ADDR_W-1:0]        base_q;
  reg  [`SSBS_ADDR_W-1:0]        base_d;
  reg  [`SSBS_CNT_W-1:0]         idx_q;
  reg  [`SSBS_CNT_W-1:0]         idx_d;
  reg                            act_q;
  reg                            act_d;
  reg                            bwr_q;
  reg                            bwr_d;
  reg                            acc_d;
  reg  [`SSBS_ADDR_W-1:0]        acc_addr_d;
  reg                            rd_d;
  reg                            wr_d;
  reg  [`SSBS_BYTES-1:0]         be_d;
  wire                           run;
  wire                           wr_block;

  // Sleep takes effect at once; a hold freezes everything else
  assign run      = clk_en & ~sleep_q;
  // Writes in or just after sleep are turned into aborts
  assign wr_block = ~st_is_run;

  always @* begin
    base_d     = base_q;
    idx_d      = idx_q;
    act_d      = act_q;
    bwr_d      = bwr_q;
    acc_d      = 1'b0;
    acc_addr_d = base_q;
    if (!advance_load_n) begin
      if (chip_select) begin
        base_d     = addr;
        idx_d      = {`SSBS_CNT_W{1'b0}};
        act_d      = 1'b1;
        bwr_d      = ~write_n;
        acc_d      = 1'b1;
        acc_addr_d = addr;
      end else begin
        act_d = 1'b0;
      end
    end else if (act_q) begin
      idx_d      = idx_q + 1'b1;
      acc_d      = 1'b1;
      acc_addr_d = {base_q[`SSBS_ADDR_W-1:`SSBS_CNT_W],
                    burst_low(base_q[`SSBS_CNT_W-1:0], idx_d, order_q)};
    end
    rd_d = acc_d & ~bwr_d;
    if (acc_d && bwr_d && !wr_block) begin
      be_d = lane_req;
    end else begin
      be_d = {`SSBS_BYTES{1'b0}};
    end
    wr_d = |be_d;
  end

  // ==========================================================
  // Access and data-timing outputs
  reg  [`SSBS_ADDR_W-1:0]        mem_addr_q;
  reg                            mem_rd_q;
  reg                            mem_wr_q;
  reg  [`SSBS_BYTES-1:0]         mem_be_q;
  reg                            dq_drive_n_q;
  reg                            wtake_q;
  reg                            desel_q;

  // Data timing: flow-through drives reads one edge after the command and
  // pipeline two; the write-data strobe follows the same offsets.

  always @(posedge clock) begin
    if (!nrst) begin
      base_q       <= {`SSBS_ADDR_W{1'b0}};
      idx_q        <= {`SSBS_CNT_W{1'b0}};
      act_q        <= 1'b0;
      bwr_q        <= 1'b0;
      mem_addr_q   <= {`SSBS_ADDR_W{1'b0}};
      mem_rd_q     <= 1'b0;
      mem_wr_q     <= 1'b0;
      mem_be_q     <= {`SSBS_BYTES{1'b0}};
      dq_drive_n_q <= 1'b1;
      wtake_q      <= 1'b0;
      desel_q      <= 1'b1;
    end else if (sleep_q) begin
      // Burst state stays put; only the outward strobes drop
      mem_rd_q     <= 1'b0;
      mem_wr_q     <= 1'b0;
      mem_be_q     <= {`SSBS_BYTES{1'b0}};
      dq_drive_n_q <= 1'b1;
      wtake_q      <= 1'b0;
      desel_q      <= 1'b1;
    end else if (run) begin
      base_q       <= base_d;
      idx_q        <= idx_d;
      act_q        <= act_d;
      bwr_q        <= bwr_d;
      mem_addr_q   <= acc_addr_d;
      mem_rd_q     <= rd_d;
      mem_wr_q     <= wr_d;
      mem_be_q     <= be_d;
      desel_q      <= ~acc_d;
      // Flow-through drives read data one stage earlier
      if (ft_q) begin
        dq_drive_n_q <= ~rd_d;
        wtake_q      <= wr_d;
      end else begin
        dq_drive_n_q <= ~mem_rd_q;
        wtake_q      <= mem_wr_q;
      end
    end
  end

  // ==========================================================
  // Register port
  reg  [31:0]                    rdata_q;
  reg  [31:0]                    rdata_d;

  always @* begin
    rdata_d = 32'h00000000;
    case (reg_addr)
      `SSBS_REG_STATUS: begin
        rdata_d[`SSBS_ST_SLEEP]  = sleep_act_q;
        rdata_d[`SSBS_ST_RECOV]  = recov_act_q;
        rdata_d[`SSBS_ST_BURST]  = act_q;
        rdata_d[`SSBS_ST_WRITE]  = bwr_q;
        rdata_d[`SSBS_ST_FLOW]   = ft_q;
        rdata_d[`SSBS_ST_ORDER]  = order_q;
        rdata_d[`SSBS_ST_IDX_LO+`SSBS_CNT_W-1:`SSBS_ST_IDX_LO] = idx_q;
      end
      `SSBS_REG_RECOVERY: begin
        rdata_d[`SSBS_RECOV_W-1:0] = recov_cfg_q;
      end
      `SSBS_REG_ADDR: begin
        rdata_d[`SSBS_ADDR_W-1:0] = base_q;
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!nrst) begin
      recov_cfg_q <= RECOV_RST;
      rdata_q     <= 32'h00000000;
    end else if (clk_en) begin
      if (reg_wr && !sleep_q && reg_addr == `SSBS_REG_RECOVERY) begin
        recov_cfg_q <= reg_wdata[`SSBS_RECOV_W-1:0];
      end
      if (reg_rd) begin
        rdata_q <= rdata_d;
      end else begin
        rdata_q <= 32'h00000000;
      end
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata    = rdata_q;
  assign mem_addr     = mem_addr_q;
  assign mem_rd       = mem_rd_q;
  assign mem_wr       = mem_wr_q;
  assign mem_byte_en  = mem_be_q;
  assign dq_drive_n   = dq_drive_n_q;
  assign wdata_take   = wtake_q;
  assign deselected   = desel_q;
  assign sleep_active = sleep_act_q;
  assign recovering   = recov_act_q;
  assign burst_index  = idx_q;

endmodule

// ==== tb/ssbs_ctrl_sva.sv ====
// Port assertions for the burst and sleep controller
`include "ssbs_defs.vh"
// ========================================
// Checker
module ssbs_chk (
  input logic                    clock,
  input logic                    nrst,
  input logic                    clk_en,
  input logic                    chip_select,
  input logic                    advance_load_n,
  input logic                    write_n,
  input logic [`SSBS_BYTES-1:0]  byte_wr_n,
  input logic [`SSBS_ADDR_W-1:0] addr,
  input logic                    burst_order_select,
  input logic                    flow_through_select,
  input logic                    sleep_request,
  input logic [`SSBS_ADDR_W-1:0] mem_addr,
  input logic                    mem_rd,
  input logic                    mem_wr,
  input logic [`SSBS_BYTES-1:0]  mem_byte_en,
  input logic                    dq_drive_n,
  input logic                    wdata_take,
  input logic                    sleep_active,
  input logic                    recovering,
  input logic [`SSBS_CNT_W-1:0]  burst_index
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic [1:0] req_q;
  logic       quiet;
  logic       run;
  // Synced sleep drops commands one edge before sleep_active shows it
  always_ff @(posedge clock) req_q <= {req_q[0], sleep_request};
  assign quiet = !sleep_active && !sleep_request && req_q == 2'h0;
  assign run   = clk_en && quiet;
  sequence ld_rd_s;
    run && chip_select && !advance_load_n && write_n;
  endsequence
  sequence ld_wr_s;
    run && !recovering && chip_select && !advance_load_n && !write_n && byte_wr_n != 4'hF;
  endsequence
  sequence cont_s;
    run && advance_load_n;
  endsequence
  hold_freeze_a: assert property (
    !clk_en && quiet |=> $stable({mem_addr, mem_rd, mem_wr, dq_drive_n, burst_index}))
    else $error("outputs moved during a hold cycle");
  load_read_a: assert property (
    ld_rd_s |=> mem_rd && mem_addr == $past(addr) && burst_index == 2'h0
      && (!$past(flow_through_select) || !dq_drive_n))
    else $error("load read not issued at the given address");
  lin_step_a: assert property (
    (mem_rd && !burst_order_select) ##0 cont_s |=> mem_rd && mem_addr >> 2 == $past(mem_addr) >> 2
      && mem_addr[1:0] == $past(mem_addr[1:0]) + 2'h1 && burst_index == $past(burst_index) + 2'h1)
    else $error("linear step wrong");
  ilv_step_a: assert property (
    (mem_rd && burst_order_select) ##0 cont_s |=> mem_addr >> 2 == $past(mem_addr) >> 2
      && mem_addr[1:0] == ($past(mem_addr[1:0]) ^ $past(burst_index) ^ ($past(burst_index) + 2'h1)))
    else $error("interleaved step wrong");
  burst_wrap_a: assert property (
    ld_rd_s ##1 cont_s [*4] |=> mem_addr == $past(addr, 5))
    else $error("fifth access does not repeat the loaded address");
  write_take_a: assert property (
    ld_wr_s ##0 flow_through_select |=> mem_wr && wdata_take && mem_byte_en == ~$past(byte_wr_n))
    else $error("flow write not issued");
  take_pipe_a: assert property (
    ld_wr_s ##0 !flow_through_select ##1 clk_en |=> wdata_take && dq_drive_n)
    else $error("pipelined write data not taken on time");
  sleep_entry_a: assert property (
    sleep_request [*4] |-> sleep_active && dq_drive_n && !mem_rd && !mem_wr)
    else $error("sleep not entered or outputs active in sleep");
  recov_end_a: assert property (
    $fell(sleep_active) |-> ##[0:1] recovering [*8] ##[10:40] !recovering)
    else $error("recovery length wrong");
endmodule

bind ssbs_ctrl ssbs_chk u_ssbs_chk (.clock, .nrst, .clk_en, .chip_select, .advance_load_n,
  .write_n, .byte_wr_n, .addr, .burst_order_select, .flow_through_select, .sleep_request,
  .mem_addr, .mem_rd, .mem_wr, .mem_byte_en, .dq_drive_n, .wdata_take, .sleep_active,
  .recovering, .burst_index);

// ==== tb/ssbs_host.sv ====
// Memory controller model driving the command pins
`include "ssbs_defs.vh"
module ssbs_host #(
  parameter int REC = 30
) (
  input  logic                    clock,
  output logic                    chip_select,
  output logic                    advance_load_n,
  output logic                    write_n,
  output logic [`SSBS_BYTES-1:0]  byte_wr_n,
  output logic [`SSBS_ADDR_W-1:0] addr,
  output logic                    sleep_request
);
  timeunit 1ns;
  timeprecision 1ps;
  int rec_left = 0;
  initial begin
    {chip_select, advance_load_n, write_n, byte_wr_n} = 7'h0F;
    addr = 18'h0;
    sleep_request = 1'b0;
  end
  // Recovery window is counted from the last edge that saw sleep high
  always @(posedge clock)
    if (sleep_request) rec_left <= REC;
    else if (rec_left > 0) rec_left <= rec_left - 1;
  // Address is scrambled when unused so a stale value cannot pass
  task automatic cmd(input logic sel, ld, wr, input logic [3:0] be, input logic [17:0] a);
    @(posedge clock);
    chip_select    <= sel;
    advance_load_n <= !ld;
    write_n        <= !(wr && rec_left == 0);
    byte_wr_n      <= be;
    addr           <= (sel && ld) ? a : ~addr;
  endtask
  task automatic sleep_on;
    repeat (3) @(posedge clock);
    sleep_request <= 1'b1;
  endtask
  task automatic sleep_off;
    @(posedge clock);
    sleep_request <= 1'b0;
  endtask
endmodule

// ==== tb/ssbs_ctrl_tb.sv ====
// Self-checking bench for the burst and sleep controller
`include "ssbs_defs.vh"
module ssbs_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     clock = 1'b0;
  logic                     nrst = 1'b0;
  logic                     clk_en = 1'b0;
  logic                     reg_wr = 1'b0;
  logic                     reg_rd = 1'b0;
  logic                     burst_order_select = 1'b0;
  logic                     flow_through_select = 1'b1;
  logic [`SSBS_RADDR_W-1:0] reg_addr = 4'h0;
  logic [31:0]              reg_wdata = 32'h0;
  logic [31:0]              reg_rdata;
  logic                     chip_select, advance_load_n, write_n, sleep_request;
  logic [`SSBS_BYTES-1:0]   byte_wr_n, mem_byte_en;
  logic [`SSBS_ADDR_W-1:0]  addr, mem_addr;
  logic                     mem_rd, mem_wr, dq_drive_n, wdata_take, deselected;
  logic                     sleep_active, recovering;
  logic [`SSBS_CNT_W-1:0]   burst_index;
  int                       err_total = 0;
  int                       check_count = 0;
  ssbs_ctrl u_ssbs_ctrl (.clock, .nrst, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .chip_select, .advance_load_n, .write_n, .byte_wr_n, .addr,
    .burst_order_select, .flow_through_select, .sleep_request, .mem_addr, .mem_rd, .mem_wr,
    .mem_byte_en, .dq_drive_n, .wdata_take, .deselected, .sleep_active, .recovering,
    .burst_index);
  ssbs_host u_ssbs_host (.clock, .chip_select, .advance_load_n, .write_n, .byte_wr_n, .addr,
    .sleep_request);
  always #2 clock = ~clock;
  // ========================================
  // Helpers
  task automatic chk(input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_check(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  function automatic logic [17:0] nxt(input logic [17:0] a, input int j, input logic ilv);
    nxt = a;
    nxt[1:0] = ilv ? a[1:0] ^ j[1:0] : a[1:0] + j[1:0];
  endfunction
  // Load plus continues up to last; step 5 is a deselect, random hold cycles between except in five-step read bursts
  task automatic burst(input logic ilv, wr, input logic [17:0] a, input int last);
    logic [17:0] e;
    logic [3:0]  be;
    logic        h, ew;
    int          j, ix;
    j = 0;
    ix = 0;
    ew = 1'b0;
    e = a;
    while (j <= last) begin
      // Long read bursts run without holds so the wrap check sees four continues
      h = j > 0 && j < 5 && (wr || last < 5) && $urandom_range(3) == 0;
      be = (j == 1) ? 4'hF : 4'($urandom_range(14));
      u_ssbs_host.cmd(j < 5, j == 0 || j == 5, wr, be, a);
      clk_en <= !h;
      #1;
      if (j > 0) begin
        chk(mem_wr, ew);
        if (!wr || ew) chk(mem_addr, e);
        chk(burst_index, ix[1:0]);
      end
      if (!h) begin
        e = nxt(a, j, ilv);
        ix = j;
        ew = wr && be != 4'hF;
        j++;
      end
    end
    if (last == 5) begin
      @(posedge clock);
      #1 chk(deselected, 1'b1);
    end
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ========================================
  // Sequence
  initial begin
    #20000;
    err_total++;
    summarize();
  end
  initial begin
    logic [17:0] a;
    void'($urandom(32'hCA8DE96C));
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    clk_en <= 1'b1;
    reg_check(4'h0, 32'h10);
    reg_check(4'h4, 32'h19);
    reg_write(4'h4, 32'h1A);
    reg_check(4'h4, 32'h1A);
    reg_check(4'hC, 32'h0);
    for (int m = 0; m < 4; m++) begin
      burst_order_select <= m[0];
      flow_through_select <= m[1];
      repeat (4) @(posedge clock);
      burst(m[0], 1'b0, 18'($urandom), 3);
      burst(m[0], 1'b0, 18'($urandom), 5);
      burst(m[0], 1'b1, 18'($urandom), 5);
      burst(m[0], 1'($urandom), 18'($urandom), 5);
    end
    // Burst left open across sleep; hold keeps the load from repeating
    a = 18'($urandom);
    u_ssbs_host.cmd(1'b1, 1'b1, 1'b0, 4'h0, a);
    @(posedge clock);
    clk_en <= 1'b0;
    u_ssbs_host.sleep_on();
    repeat (4) @(posedge clock);
    clk_en <= 1'b1;
    u_ssbs_host.cmd(1'b1, 1'b1, 1'b1, 4'h0, ~a);
    @(posedge clock);
    clk_en <= 1'b0;
    #1 chk(mem_wr, 1'b0);
    chk(sleep_active, 1'b1);
    u_ssbs_host.sleep_off();
    for (int i = 0; i < 80 && (recovering !== 1'b0 || sleep_active !== 1'b0); i++) begin
      @(posedge clock);
      #1;
    end
    chk(recovering, 1'b0);
    u_ssbs_host.cmd(1'b1, 1'b0, 1'b0, 4'hF, a);
    clk_en <= 1'b1;
    @(posedge clock);
    #1 chk(mem_addr, nxt(a, 1, 1'b1));
    chk(burst_index, 2'h1);
    summarize();
  end
endmodule
